// File: rtl/afp_defs.vh
`ifndef AFP_DEFS_VH
`define AFP_DEFS_VH

// Frame-based memory commands on the command/byte-enable lines
`define AFP_CMD_MEM_READ   4'h6
`define AFP_CMD_MEM_WRITE  4'h7
// Pipelined command: this bit marks a write request
`define AFP_PIPE_WRITE_BIT 2
// Status codes sent along with grant
`define AFP_ST_IDLE        3'h0
`define AFP_ST_PIPE        3'h0
`define AFP_ST_FRAME       3'h7
// Initiator completion codes
`define AFP_INIT_OK        2'h0
`define AFP_INIT_STOPPED   2'h1
`define AFP_INIT_ABORT     2'h2
// Cycles the initiator waits for a target to claim the access
`define AFP_CLAIM_WAIT     4'h5
// Target window base and word index position
`define AFP_BASE_ADDR      32'h0000_0000
`define AFP_IDX_LSB        2

`endif

// File: rtl/afp_mem.v
module afp_mem #(
  parameter AW = 4
) (
  input  wire          clk_in,
  input  wire          rst_n_in,
  input  wire          wr_en_in,
  input  wire [AW-1:0] wr_addr_in,
  input  wire [31:0]   wr_data_in,
  input  wire [3:0]    wr_be_n_in,
  input  wire [AW-1:0] rd_addr_in,
  output reg  [31:0]   rd_data_out
);
  reg [31:0] mem [0:(1<<AW)-1];  // Target storage words
  integer    i;                  // Byte lane index

  // Write enabled byte lanes only; active-low enables
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (!wr_be_n_in[i]) begin
          mem[wr_addr_in][i*8 +: 8] <= wr_data_in[i*8 +: 8];
        end
      end
    end
  end

  // Registered read port
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= 32'h0000_0000;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end
endmodule

// File: rtl/afp_port.v
// Contract
// [R1] Assert target select on own address hit
// [R2] Initiator samples target select for claim
// [R3] Master requests port with request input
// [R4] Grant plus three-bit status directs port use
// [R5] Command in address, byte enables in data
// [R6] Pipelined commands use their own decode
// [R7] Initiator parity: write all, read address
// [R8] Target parity on each memory read phase
// [R9] Even parity over data and command lines
// [R10] Parity unused in pipelined and sideband modes
// [R11] Reset acts asynchronously
// [R12] All pin drivers float during reset
// [R13] All port logic runs on port clock
// [R14] Master resets from same reset line
// [R15] Status 111 with grant allows frame
// [R16] Master no waits in first write block
// [R17] Stop is input as initiator, output as target
// [R18] Parity presented one clock after its phase
`include "afp_defs.vh"

module afp_port #(
  parameter        AW          = 4,
  parameter [31:0] TARGET_BASE = `AFP_BASE_ADDR
) (
  input  wire        clk_in,                 // Port clock [R13]
  input  wire        rst_n_in,
  input  wire        pipe_mode_in,           // High: pipelined/sideband operation
  input  wire        bus_request_n_in,
  input  wire        frame_n_in,
  input  wire        initiator_ready_n_in,
  input  wire        target_ready_n_in,
  input  wire        target_select_n_in,
  input  wire        stop_n_in,
  input  wire        pipe_enqueue_n_in,
  input  wire [31:0] ad_in,
  input  wire [3:0]  cmd_byte_enable_n_in,
  input  wire        init_req_in,            // Start one initiator transfer
  input  wire        init_write_in,
  input  wire [31:0] init_addr_in,
  input  wire [31:0] init_data_in,
  input  wire [3:0]  init_be_n_in,
  output reg         grant_n_out,
  output reg  [2:0]  grant_status_code_out,
  output reg         frame_n_out,
  output reg         frame_oe_n_out,
  output reg         initiator_ready_n_out,
  output reg         irdy_oe_n_out,
  output reg         target_ready_n_out,
  output reg         trdy_oe_n_out,
  output reg         target_select_n_out,
  output reg         devsel_oe_n_out,
  output reg         stop_n_out,
  output reg         stop_oe_n_out,
  output reg  [31:0] ad_out,
  output reg         ad_oe_n_out,
  output reg  [3:0]  cmd_byte_enable_n_out,
  output reg         cbe_oe_n_out,
  output reg         bus_parity_out,
  output reg         par_oe_n_out,
  output reg         init_done_out,
  output reg  [1:0]  init_status_out,
  output reg  [31:0] init_rdata_out,
  output reg         pipe_cmd_valid_out,
  output reg         pipe_cmd_write_out
);
  localparam T_IDLE = 4'b0001;
  localparam T_WAIT = 4'b0010;
  localparam T_DATA = 4'b0100;
  localparam T_TURN = 4'b1000;
  localparam I_IDLE = 4'b0001;
  localparam I_ADDR = 4'b0010;
  localparam I_DATA = 4'b0100;
  localparam I_TURN = 4'b1000;
  localparam SW     = 43;

  // Even parity bit over address/data and command lines
  function par_of;
    input [31:0] ad;
    input [3:0]  cbe;
    begin
      par_of = ^{ad, cbe};  // [R9]
    end
  endfunction

  // Frame-based memory command decode
  function frame_is_mem;
    input [3:0] cmd;
    begin
      frame_is_mem = (cmd == `AFP_CMD_MEM_READ) || (cmd == `AFP_CMD_MEM_WRITE);
    end
  endfunction

  // Pipelined command decode, kept apart from the frame decode
  function pipe_is_write;
    input [3:0] cmd;
    begin
      pipe_is_write = cmd[`AFP_PIPE_WRITE_BIT];
    end
  endfunction

  wire [SW-1:0] pin_raw;     // Raw pin inputs
  reg  [SW-1:0] sync1;       // First synchroniser stage
  reg  [SW-1:0] sync2;       // Second synchroniser stage
  reg           frame_q;     // Previous synced frame level
  reg  [3:0]    t_state;     // Target state
  reg  [3:0]    i_state;     // Initiator state
  reg  [AW-1:0] t_addr;      // Target word index
  reg           t_write;     // Target access is a write
  reg           i_write;     // Initiator access is a write
  reg  [31:0]   i_data;      // Initiator write data
  reg  [3:0]    i_be_n;      // Initiator byte enables
  reg  [3:0]    wait_cnt;    // Claim wait counter
  reg           par_arm;     // A parity phase is on the bus now
  reg  [31:0]   par_ad;      // Phase data for parity
  reg  [3:0]    par_cbe;     // Phase command/enables for parity
  reg           mem_we;      // Target memory write strobe
  reg  [31:0]   mem_wdata;
  reg  [3:0]    mem_be_n;
  reg  [AW-1:0] mem_waddr;
  reg  [AW-1:0] mem_raddr;   // Combinational read index
  wire [31:0]   mem_rdata;

  assign pin_raw = {bus_request_n_in, frame_n_in, initiator_ready_n_in, target_ready_n_in,
                    target_select_n_in, stop_n_in, pipe_enqueue_n_in,
                    cmd_byte_enable_n_in, ad_in};

  wire        req_s    = sync2[42];
  wire        frame_s  = sync2[41];
  wire        irdy_s   = sync2[40];
  wire        trdy_s   = sync2[39];
  wire        devsel_s = sync2[38];
  wire        stop_s   = sync2[37];
  wire        pipe_s   = sync2[36];
  wire [3:0]  cbe_s    = sync2[35:32];
  wire [31:0] ad_s     = sync2[31:0];
  wire        t_last   = (t_addr == {AW{1'b1}});
  wire        hit      = (ad_s[31:AW+`AFP_IDX_LSB] == TARGET_BASE[31:AW+`AFP_IDX_LSB]);
  wire        frame_go = !frame_s && frame_q;

  // Read index: the decoded address on a claim, the next word when advancing
  always @* begin
    mem_raddr = t_addr;
    if (t_state == T_IDLE) begin
      mem_raddr = ad_s[AW+`AFP_IDX_LSB-1:`AFP_IDX_LSB];
    end else if (t_state == T_DATA) begin
      mem_raddr = t_addr + {{(AW-1){1'b0}}, 1'b1};
    end
  end

  // Two-flop synchroniser for every pin input
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin  // [R11]
      sync1   <= {SW{1'b1}};
      sync2   <= {SW{1'b1}};
      frame_q <= 1'b1;
    end else begin
      sync1   <= pin_raw;
      sync2   <= sync1;
      frame_q <= frame_s;
    end
  end

  // Bus engine: arbiter, target, initiator and parity share the pin drivers
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin  // [R11]
      grant_n_out           <= 1'b1;
      grant_status_code_out <= `AFP_ST_IDLE;
      frame_n_out           <= 1'b1;
      initiator_ready_n_out <= 1'b1;
      target_ready_n_out    <= 1'b1;
      target_select_n_out   <= 1'b1;
      stop_n_out            <= 1'b1;
      ad_out                <= 32'h0000_0000;
      cmd_byte_enable_n_out <= 4'hF;
      bus_parity_out        <= 1'b0;
      // Every driver released while reset is held [R12]
      frame_oe_n_out        <= 1'b1;
      irdy_oe_n_out         <= 1'b1;
      trdy_oe_n_out         <= 1'b1;
      devsel_oe_n_out       <= 1'b1;
      stop_oe_n_out         <= 1'b1;
      ad_oe_n_out           <= 1'b1;
      cbe_oe_n_out          <= 1'b1;
      par_oe_n_out          <= 1'b1;
      init_done_out         <= 1'b0;
      init_status_out       <= `AFP_INIT_OK;
      init_rdata_out        <= 32'h0000_0000;
      pipe_cmd_valid_out    <= 1'b0;
      pipe_cmd_write_out    <= 1'b0;
      t_state               <= T_IDLE;
      i_state               <= I_IDLE;
      t_addr                <= {AW{1'b0}};
      t_write               <= 1'b0;
      i_write               <= 1'b0;
      i_data                <= 32'h0000_0000;
      i_be_n                <= 4'hF;
      wait_cnt              <= 4'h0;
      par_arm               <= 1'b0;
      par_ad                <= 32'h0000_0000;
      par_cbe               <= 4'h0;
      mem_we                <= 1'b0;
      mem_wdata             <= 32'h0000_0000;
      mem_be_n              <= 4'hF;
      mem_waddr             <= {AW{1'b0}};
    end else begin
      mem_we             <= 1'b0;
      init_done_out      <= 1'b0;
      pipe_cmd_valid_out <= 1'b0;
      par_arm            <= 1'b0;
      // Parity follows its phase by one clock, off in pipelined mode
      par_oe_n_out   <= !(par_arm && !pipe_mode_in);  // [R18] [R10]
      bus_parity_out <= par_of(par_ad, par_cbe);      // [R9]

      // Grant the requesting master when the port is free [R3]
      if (!req_s && i_state == I_IDLE && t_state == T_IDLE && !init_req_in) begin
        grant_n_out           <= 1'b0;  // [R4]
        grant_status_code_out <= pipe_mode_in ? `AFP_ST_PIPE : `AFP_ST_FRAME;  // [R15]
      end else begin
        grant_n_out           <= 1'b1;
        grant_status_code_out <= `AFP_ST_IDLE;
      end

      // Pipelined request capture with its own command decode
      if (pipe_mode_in && !pipe_s) begin
        pipe_cmd_valid_out <= 1'b1;
        pipe_cmd_write_out <= pipe_is_write(cbe_s);  // [R6]
      end

      // Target side
      case (t_state)
        T_IDLE: begin
          if (frame_go && i_state == I_IDLE && !pipe_mode_in && frame_is_mem(cbe_s) && hit) begin
            target_select_n_out <= 1'b0;  // [R1]
            devsel_oe_n_out     <= 1'b0;
            trdy_oe_n_out       <= 1'b0;
            stop_oe_n_out       <= 1'b0;  // [R17]
            t_addr              <= ad_s[AW+`AFP_IDX_LSB-1:`AFP_IDX_LSB];
            t_write             <= (cbe_s == `AFP_CMD_MEM_WRITE);  // [R5]
            t_state             <= T_WAIT;
          end
        end
        T_WAIT: begin
          target_ready_n_out <= 1'b0;
          stop_n_out         <= !t_last;  // Disconnect at the window end [R17]
          if (!t_write) begin
            ad_out      <= mem_rdata;
            ad_oe_n_out <= 1'b0;
            par_arm     <= 1'b1;  // [R8]
            par_ad      <= mem_rdata;
            par_cbe     <= cbe_s;
          end
          t_state <= T_DATA;
        end
        T_DATA: begin
          if (!irdy_s) begin
            if (t_write) begin
              mem_we    <= 1'b1;
              mem_waddr <= t_addr;
              mem_wdata <= ad_s;
              mem_be_n  <= cbe_s;  // Byte enables pick lanes [R5]
            end
            target_ready_n_out <= 1'b1;
            if (frame_s || t_last) begin
              target_select_n_out <= 1'b1;
              stop_n_out          <= 1'b1;
              ad_oe_n_out         <= 1'b1;
              t_state             <= T_TURN;
            end else begin
              t_addr  <= mem_raddr;
              t_state <= T_WAIT;
            end
          end
        end
        T_TURN: begin
          devsel_oe_n_out <= 1'b1;
          trdy_oe_n_out   <= 1'b1;
          stop_oe_n_out   <= 1'b1;
          t_state         <= T_IDLE;
        end
        default: begin
          t_state <= T_IDLE;
        end
      endcase

      // Initiator side: one data phase per transfer
      case (i_state)
        I_IDLE: begin
          if (init_req_in && grant_n_out && req_s && t_state == T_IDLE && !pipe_mode_in) begin
            frame_n_out           <= 1'b0;
            frame_oe_n_out        <= 1'b0;
            irdy_oe_n_out         <= 1'b0;
            ad_out                <= init_addr_in;
            ad_oe_n_out           <= 1'b0;
            cmd_byte_enable_n_out <= init_write_in ? `AFP_CMD_MEM_WRITE : `AFP_CMD_MEM_READ;
            cbe_oe_n_out          <= 1'b0;
            par_arm               <= 1'b1;  // Address phase parity [R7]
            par_ad                <= init_addr_in;
            par_cbe               <= init_write_in ? `AFP_CMD_MEM_WRITE : `AFP_CMD_MEM_READ;
            i_write               <= init_write_in;
            i_data                <= init_data_in;
            i_be_n                <= init_be_n_in;
            wait_cnt              <= 4'h0;
            i_state               <= I_ADDR;
          end
        end
        I_ADDR: begin
          frame_n_out           <= 1'b1;
          initiator_ready_n_out <= 1'b0;
          cmd_byte_enable_n_out <= i_be_n;  // [R5]
          if (i_write) begin
            ad_out  <= i_data;
            par_arm <= 1'b1;  // Write data phase parity [R7]
            par_ad  <= i_data;
            par_cbe <= i_be_n;
          end else begin
            ad_oe_n_out <= 1'b1;
          end
          i_state <= I_DATA;
        end
        I_DATA: begin
          wait_cnt <= wait_cnt + 4'h1;
          if (!stop_s || (!trdy_s && !devsel_s) ||
              (devsel_s && wait_cnt == `AFP_CLAIM_WAIT)) begin  // [R2] [R17]
            init_done_out         <= 1'b1;
            init_rdata_out        <= ad_s;
            init_status_out       <= !stop_s ? `AFP_INIT_STOPPED :
                                     (devsel_s ? `AFP_INIT_ABORT : `AFP_INIT_OK);
            initiator_ready_n_out <= 1'b1;
            frame_oe_n_out        <= 1'b1;
            ad_oe_n_out           <= 1'b1;
            cbe_oe_n_out          <= 1'b1;
            i_state               <= I_TURN;
          end
        end
        I_TURN: begin
          irdy_oe_n_out <= 1'b1;
          i_state       <= I_IDLE;
        end
        default: begin
          i_state <= I_IDLE;
        end
      endcase
    end
  end

  // Target storage
  afp_mem #(
    .AW (AW)
  ) u_mem (
    .clk_in      (clk_in),
    .rst_n_in    (rst_n_in),
    .wr_en_in    (mem_we),
    .wr_addr_in  (mem_waddr),
    .wr_data_in  (mem_wdata),
    .wr_be_n_in  (mem_be_n),
    .rd_addr_in  (mem_raddr),
    .rd_data_out (mem_rdata)
  );
endmodule

// File: bench/afp_port_sva.sv
module afp_port_sva #(
  parameter AW = 4
) (
  input wire        clk_in,
  input wire        rst_n_in,
  input wire        pipe_mode_in,
  input wire        frame_n_in,
  input wire        target_select_n_in,
  input wire [31:0] ad_in,
  input wire [3:0]  cmd_byte_enable_n_in,
  input wire        grant_n_out,
  input wire [2:0]  grant_status_code_out,
  input wire        frame_n_out,
  input wire        frame_oe_n_out,
  input wire        irdy_oe_n_out,
  input wire        trdy_oe_n_out,
  input wire        target_ready_n_out,
  input wire        target_select_n_out,
  input wire        devsel_oe_n_out,
  input wire        stop_oe_n_out,
  input wire [31:0] ad_out,
  input wire        ad_oe_n_out,
  input wire [3:0]  cmd_byte_enable_n_out,
  input wire        cbe_oe_n_out,
  input wire        bus_parity_out,
  input wire        par_oe_n_out,
  input wire        init_done_out,
  input wire [1:0]  init_status_out,
  input wire        pipe_cmd_valid_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Every pin enable still off at the first edge after release
  wire oe_all_off = &{frame_oe_n_out, irdy_oe_n_out, trdy_oe_n_out, devsel_oe_n_out,
                      stop_oe_n_out, ad_oe_n_out, cbe_oe_n_out, par_oe_n_out, grant_n_out};
  // Target decode of a memory command inside the window, port not initiating
  wire tgt_dec = (cmd_byte_enable_n_in[3:1] == 3'h3) && ((ad_in >> (AW + 2)) == 32'h0)
                 && !pipe_mode_in && devsel_oe_n_out && frame_oe_n_out;
  property p_rst; $rose(rst_n_in) |-> oe_all_off; endproperty
  a_rst: assert property (p_rst) else $error("pins driven at reset release");
  property p_st0; grant_n_out |-> grant_status_code_out == 3'h0; endproperty
  a_st0: assert property (p_st0) else $error("status set without grant");
  property p_st7; !grant_n_out && !pipe_mode_in && !$past(pipe_mode_in)
    |-> grant_status_code_out == 3'h7; endproperty
  a_st7: assert property (p_st7) else $error("frame grant without status 7");
  property p_claim; $fell(frame_n_in) && tgt_dec
    |-> ##[2:4] (!devsel_oe_n_out && !target_select_n_out); endproperty
  a_claim: assert property (p_claim) else $error("own address not claimed");
  property p_paddr; $fell(frame_n_out) && !frame_oe_n_out |=> !par_oe_n_out
    && bus_parity_out == ^{$past(ad_out), $past(cmd_byte_enable_n_out)}; endproperty
  a_paddr: assert property (p_paddr) else $error("address parity wrong");
  property p_pwr; $rose(frame_n_out) && !ad_oe_n_out && !frame_oe_n_out |=> !par_oe_n_out
    && bus_parity_out == ^{$past(ad_out), $past(cmd_byte_enable_n_out)}; endproperty
  a_pwr: assert property (p_pwr) else $error("write data parity wrong");
  property p_ptgt; !trdy_oe_n_out && !target_ready_n_out && !ad_oe_n_out |=> !par_oe_n_out
    && bus_parity_out == ^{$past(ad_out), $past(cmd_byte_enable_n_in)}; endproperty
  a_ptgt: assert property (p_ptgt) else $error("target read parity wrong");
  property p_ppipe; pipe_mode_in && $past(pipe_mode_in)
    |-> par_oe_n_out && frame_oe_n_out; endproperty
  a_ppipe: assert property (p_ppipe) else $error("parity or frame driven in pipe mode");
  property p_noclm; init_done_out && init_status_out == 2'h2
    |-> $past(target_select_n_in); endproperty
  a_noclm: assert property (p_noclm) else $error("no-claim status while claimed");
  property p_done; init_done_out |=> !init_done_out; endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
  c_claim: cover property ($fell(frame_n_in) && tgt_dec ##3 !target_select_n_out);
  c_done: cover property (init_done_out && init_status_out == 2'h1);
  c_pipe: cover property (pipe_cmd_valid_out);
endmodule

bind afp_port afp_port_sva #(.AW(AW)) u_sva (.*);

// File: bench/afp_gfx_model.sv
// Far-side agent answering the port's own initiator cycles
module afp_gfx_model #(
  parameter logic [31:0] RDATA = 32'h1357_9BDF
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        frame_n_in,
  input  wire logic        irdy_oe_n_in,
  input  wire logic [3:0]  cbe_n_in,
  input  wire logic        claim_in,
  input  wire logic        stop_in,
  output logic             devsel_n_out,
  output logic             trdy_n_out,
  output logic             stop_n_out,
  output logic             ad_en_out,
  output logic [31:0]      ad_out
);
  logic busy; // A cycle of the port is being answered
  assign ad_out = RDATA;
  // Claim on frame, release once the port lets go of ready
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy <= 1'b0;
      {devsel_n_out, trdy_n_out, stop_n_out, ad_en_out} <= 4'hE;
    end else if (!busy && !frame_n_in) begin
      busy <= 1'b1;
      devsel_n_out <= !claim_in;
      trdy_n_out <= !claim_in || stop_in;
      stop_n_out <= !(claim_in && stop_in);
      ad_en_out <= claim_in && !stop_in && (cbe_n_in == 4'h6);
    end else if (busy && irdy_oe_n_in && frame_n_in) begin
      // Released lines return to the pull-up level
      busy <= 1'b0;
      {devsel_n_out, trdy_n_out, stop_n_out, ad_en_out} <= 4'hE;
    end
  end
endmodule

// File: bench/tb_afp_port.sv
module tb_afp_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 4;
  localparam logic [31:0] P_RD = 32'h2468_ACE1;
  // Bench-driven inputs and master-side pin drive
  logic        clk_in = 0, rst_n_in = 0, pipe_mode_in = 0, bus_request_n_in = 1;
  logic        pipe_enqueue_n_in = 1, init_req_in = 0, init_write_in = 0;
  logic [31:0] init_addr_in = 0, init_data_in = 0, m_ad = 0, rnd = 32'h315F20BB;
  logic [3:0]  init_be_n_in = 4'hF, m_cbe = 4'hF;
  logic        m_frame = 1, m_irdy = 1, m_ad_en = 0, claim = 1, stop_req = 0;
  // Design outputs and partner pins
  logic        grant_n_out, frame_n_out, frame_oe_n_out, initiator_ready_n_out, irdy_oe_n_out;
  logic        target_ready_n_out, trdy_oe_n_out, target_select_n_out, devsel_oe_n_out;
  logic        stop_n_out, stop_oe_n_out, ad_oe_n_out, cbe_oe_n_out, bus_parity_out;
  logic        par_oe_n_out, init_done_out, pipe_cmd_valid_out, pipe_cmd_write_out;
  logic        p_devsel, p_trdy, p_stop, p_ad_en;
  logic [2:0]  grant_status_code_out;
  logic [1:0]  init_status_out;
  logic [31:0] ad_out, init_rdata_out, p_ad;
  logic [3:0]  cmd_byte_enable_n_out;
  logic [34:0] note;
  logic [34:0] notes[$];
  int          err_total = 0, cmp_count = 0;
  // Wired lines with pull-ups; undriven data shows inverted values
  wire frame_n_in = m_frame & (frame_oe_n_out | frame_n_out);
  wire initiator_ready_n_in = m_irdy & (irdy_oe_n_out | initiator_ready_n_out);
  wire target_ready_n_in = p_trdy & (trdy_oe_n_out | target_ready_n_out);
  wire target_select_n_in = p_devsel & (devsel_oe_n_out | target_select_n_out);
  wire stop_n_in = p_stop & (stop_oe_n_out | stop_n_out);
  wire [31:0] ad_in = !ad_oe_n_out ? ad_out : m_ad_en ? m_ad : p_ad_en ? p_ad : ~m_ad;
  wire [3:0] cmd_byte_enable_n_in = !cbe_oe_n_out ? cmd_byte_enable_n_out :
                                    m_ad_en ? m_cbe : ~m_cbe;
  wire [8:0] floats = {frame_oe_n_out, irdy_oe_n_out, trdy_oe_n_out, devsel_oe_n_out,
                       stop_oe_n_out, ad_oe_n_out, cbe_oe_n_out, par_oe_n_out, grant_n_out};
  afp_port #(.AW(AW)) dut (.*);
  afp_gfx_model #(.RDATA(P_RD)) u_gfx (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .frame_n_in(frame_oe_n_out | frame_n_out), .irdy_oe_n_in(irdy_oe_n_out),
    .cbe_n_in(cmd_byte_enable_n_in), .claim_in(claim), .stop_in(stop_req),
    .devsel_n_out(p_devsel), .trdy_n_out(p_trdy), .stop_n_out(p_stop),
    .ad_en_out(p_ad_en), .ad_out(p_ad));
  // Clock at 20 ns
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Master cycle into the target; hit says whether a claim is due
  task automatic tgt(input logic [3:0] cmd, input logic [31:0] a, d, input logic [3:0] be,
                     input logic hit);
    int i;
    tick(1);
    m_frame <= 0;
    m_ad_en <= 1;
    m_ad <= a;
    m_cbe <= cmd;
    tick(1);
    m_frame <= 1;
    m_irdy <= 0;
    m_cbe <= be;
    m_ad_en <= (cmd == 4'h7);
    m_ad <= d;
    for (i = 0; i < 12 && target_ready_n_in !== 1'b0; i++) tick(1);
    check(i < 12, hit);
    check(stop_n_in, !(hit && (&a[AW+1:2])));
    if (hit && cmd == 4'h6) begin
      check(ad_in, d);
      tick(1);
      check({par_oe_n_out, bus_parity_out}, {1'b0, ^{d, be}});
    end
    for (i = 0; i < 12 && devsel_oe_n_out !== 1'b1; i++) tick(1);
    m_irdy <= 1;
    m_ad_en <= 0;
    m_cbe <= 4'hF;
    tick(3);
  endtask
  // Port-initiated transfer; the monitor checks the result
  task automatic init_xfer(input logic wr, input logic [1:0] st);
    int i;
    // Read data only means something on a completed, claimed read
    notes.push_back({!wr && st == 2'h0, st, (!wr && st == 2'h0) ? P_RD : 32'h0});
    rnd = lfsr(rnd);
    init_write_in <= wr;
    init_addr_in <= rnd;
    init_data_in <= ~rnd;
    init_be_n_in <= rnd[3:0];
    init_req_in <= 1;
    for (i = 0; i < 40 && init_done_out !== 1'b1; i++) tick(1);
    check(i < 40, 1);
    init_req_in <= 0;
    tick(4);
  endtask
  // Result monitor: oldest note against each done pulse
  always @(posedge clk_in) begin
    if (init_done_out === 1'b1) begin
      note = notes.size() ? notes.pop_front() : '1;
      check({init_status_out, note[34] ? init_rdata_out : 32'h0}, note[33:0]);
    end
  end
  initial begin
    int k;
    logic [31:0] d1, d2;
    tick(10);
    check(floats, 9'h1FF);
    rst_n_in <= 1;
    tick(3);
    $display("reset test done");
    bus_request_n_in <= 0;
    tick(5);
    check({grant_n_out, grant_status_code_out}, 4'h7);
    rst_n_in <= 0;
    #2;
    check(floats, 9'h1FF);
    tick(2);
    rst_n_in <= 1;
    tick(5);
    pipe_mode_in <= 1;
    tick(4);
    check(grant_status_code_out, 3'h0);
    for (k = 0; k < 2; k++) begin
      m_ad_en <= 1;
      m_cbe <= k ? 4'h4 : 4'h0;
      pipe_enqueue_n_in <= 0;
      tick(1);
      pipe_enqueue_n_in <= 1;
      for (int i = 0; i < 8 && pipe_cmd_valid_out !== 1'b1; i++) tick(1);
      check({pipe_cmd_valid_out, pipe_cmd_write_out}, {1'b1, k[0]});
      tick(3);
    end
    m_ad_en <= 0;
    pipe_mode_in <= 0;
    bus_request_n_in <= 1;
    tick(6);
    check(grant_n_out, 1);
    $display("arbiter and pipe test done");
    d1 = lfsr(rnd);
    d2 = lfsr(d1);
    tgt(4'h7, 32'h8, d1, 4'h0, 1);
    tgt(4'h7, 32'h8, d2, 4'hC, 1);
    tgt(4'h6, 32'h8, {d1[31:16], d2[15:0]}, 4'h0, 1);
    tgt(4'h7, 32'h100, d1, 4'h0, 0);
    tgt(4'h7, 32'h3C, d2, 4'h0, 1);
    $display("target test done");
    init_xfer(1, 2'h0);
    init_xfer(0, 2'h0);
    stop_req <= 1;
    init_xfer(1, 2'h1);
    stop_req <= 0;
    claim <= 0;
    init_xfer(0, 2'h2);
    $display("initiator test done");
    wrap_up();
  end
  // Watchdog against a hang
  initial begin
    #300us;
    err_total++;
    wrap_up();
  end
endmodule
